// ==== src/rdi_slave.sv ====
// Operation
// RULE1 - Device is slave; master clocks everything
// RULE2 - Bytes shift most significant bit first
// RULE3 - Data edges with clock high mean START/STOP
// RULE4 - Data line undriven after power-up
// RULE5 - Ignore bus until START is seen
// RULE6 - Ignore START during power-up sequence
// RULE7 - STOP returns device to standby
// RULE8 - Transmitter releases; receiver acks ninth clock
// RULE9 - Ack valid identifier, word address, write data
// RULE10 - Master acks each read byte to continue
// RULE11 - Identifier picks register or user space
// RULE12 - Identifier low bit: one read, zero write
// RULE13 - Ack address only on identifier match
// RULE14 - One word-address byte follows identifier
// RULE15 - Address counter cleared at power-up
// RULE16 - Random read reuses same identifier
// RULE17 - User space: 128 bytes, own identifier
// RULE18 - Write: id, address, data, each acked
// RULE19 - Read continues while master acknowledges
// RULE20 - Pointer increments, register space wraps 2Fh
// RULE21 - No master ack: release, await STOP/START
module rdi_slave (
  // Clock, reset, freeze
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Two-wire bus
  rdi_if.dev bus,
  // User side notices
  output logic wr_valid,
  output logic wr_user,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic busy,
  output logic ready
);

  ////////////////////////////////////////
  // Declarations
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic scl_last_reg;
  logic sda_last_reg;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [7:0] pwr_cnt_reg;
  logic ready_reg;
  rdi_pkg::rdi_slv_state_type state_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic got_reg;
  logic rd_reg;
  logic user_reg;
  logic ack_reg;
  logic [7:0] ptr_reg;
  logic sda_oe_reg;
  logic sda_o_reg;
  logic wr_valid_reg;
  logic wr_user_reg;
  logic [7:0] wr_addr_reg;
  logic [7:0] wr_data_reg;
  logic busy_reg;
  logic [7:0] reg_mem [0:rdi_pkg::REG_DEPTH-1];
  logic [7:0] user_mem [0:rdi_pkg::USER_DEPTH-1];
  logic [7:0] rd_byte;
  logic [7:0] ptr_inc;
  logic id_match;
  logic byte_in;
  logic mem_we;

  ////////////////////////////////////////
  // Pin synchronisers; edges are found past the second stage only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_last_reg <= 1'b1;
      sda_last_reg <= 1'b1;
    end else if (clk_en) begin
      scl_sync_reg <= {scl_sync_reg[0], bus.scl};
      sda_sync_reg <= {sda_sync_reg[0], bus.sda};
      scl_last_reg <= scl_sync_reg[1];
      sda_last_reg <= sda_sync_reg[1];
    end
  end

  // Bus events; the master alone makes the clock
  assign scl_s = scl_sync_reg[1];
  assign sda_s = sda_sync_reg[1];
  assign scl_rise = scl_s & ~scl_last_reg; // RULE1
  assign scl_fall = ~scl_s & scl_last_reg;
  assign start_det = scl_s & scl_last_reg & sda_last_reg & ~sda_s; // RULE3
  assign stop_det = scl_s & scl_last_reg & ~sda_last_reg & sda_s; // RULE3

  ////////////////////////////////////////
  // Power-up sequence; bus START is not honoured until it ends
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_cnt_reg <= 8'h00;
      ready_reg <= 1'b0;
    end else if (clk_en && !ready_reg) begin
      pwr_cnt_reg <= pwr_cnt_reg + 8'h01;
      ready_reg <= (pwr_cnt_reg == rdi_pkg::PWRUP_CYC - 8'h01);
    end
  end

  ////////////////////////////////////////
  // Decode of the received byte and of the data to send
  assign id_match = (shift_reg[7:1] == rdi_pkg::ID_REGS) ||
                    (shift_reg[7:1] == rdi_pkg::ID_USER); // RULE11
  assign byte_in = scl_fall & got_reg;
  assign mem_we = byte_in & (state_reg == rdi_pkg::S_WDATA);

  // Register space wraps at its last byte, user space at its own
  always_comb begin
    if (ptr_reg == (user_reg ? rdi_pkg::USER_LAST : rdi_pkg::REG_LAST)) begin
      ptr_inc = rdi_pkg::ADDR_RESET; // RULE20
    end else begin
      ptr_inc = ptr_reg + 8'h01; // RULE20
    end
  end

  // Locations past the register space read as zero
  always_comb begin
    if (user_reg) begin
      rd_byte = user_mem[ptr_reg[6:0]]; // RULE17
    end else if (ptr_reg <= rdi_pkg::REG_LAST) begin
      rd_byte = reg_mem[ptr_reg[5:0]];
    end else begin
      rd_byte = 8'h00;
    end
  end

  ////////////////////////////////////////
  // Storage; no reset, contents are kept like battery-backed cells
  always_ff @(posedge ref_clk) begin
    if (clk_en && mem_we) begin
      if (user_reg) begin
        user_mem[ptr_reg[6:0]] <= shift_reg; // RULE17
      end else if (ptr_reg <= rdi_pkg::REG_LAST) begin
        reg_mem[ptr_reg[5:0]] <= shift_reg;
      end
    end
  end

  ////////////////////////////////////////
  // Protocol engine: samples on clock rise, drives on clock fall
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= rdi_pkg::S_IDLE;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      got_reg <= 1'b0;
      rd_reg <= 1'b0;
      user_reg <= 1'b0;
      ack_reg <= 1'b0;
      ptr_reg <= rdi_pkg::ADDR_RESET; // RULE15
      sda_oe_reg <= 1'b0; // RULE4
    end else if (clk_en) begin
      if (start_det && ready_reg) begin
        // New or repeated START; the pointer survives for random reads
        state_reg <= rdi_pkg::S_ID; // RULE5 RULE6
        bit_cnt_reg <= 3'h0;
        got_reg <= 1'b0;
        sda_oe_reg <= 1'b0;
      end else if (stop_det) begin
        state_reg <= rdi_pkg::S_IDLE; // RULE7
        got_reg <= 1'b0;
        sda_oe_reg <= 1'b0;
      end else begin
        case (state_reg)
          rdi_pkg::S_ID, rdi_pkg::S_WORD, rdi_pkg::S_WDATA: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_s}; // RULE2
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              got_reg <= (bit_cnt_reg == 3'(rdi_pkg::BYTE_LAST_BIT));
            end else if (byte_in) begin
              got_reg <= 1'b0;
              if (state_reg == rdi_pkg::S_ID) begin
                if (id_match) begin
                  user_reg <= (shift_reg[7:1] == rdi_pkg::ID_USER); // RULE11
                  rd_reg <= shift_reg[0]; // RULE12
                  sda_oe_reg <= 1'b1; // RULE9 RULE13
                  state_reg <= rdi_pkg::S_ACK_ID;
                end else begin
                  state_reg <= rdi_pkg::S_WAIT; // RULE13
                end
              end else if (state_reg == rdi_pkg::S_WORD) begin
                ptr_reg <= shift_reg; // RULE14
                sda_oe_reg <= 1'b1; // RULE9
                state_reg <= rdi_pkg::S_ACK_WORD;
              end else begin
                sda_oe_reg <= 1'b1; // RULE9 RULE18
                state_reg <= rdi_pkg::S_ACK_DATA;
              end
            end
          end
          rdi_pkg::S_ACK_ID: begin
            if (scl_fall) begin
              bit_cnt_reg <= 3'h0;
              if (rd_reg) begin
                // Current-address read: send straight from the pointer
                shift_reg <= rd_byte;
                sda_oe_reg <= ~rd_byte[7]; // RULE2
                ptr_reg <= ptr_inc; // RULE20
                state_reg <= rdi_pkg::S_TX;
              end else begin
                sda_oe_reg <= 1'b0; // RULE8
                state_reg <= rdi_pkg::S_WORD; // RULE14
              end
            end
          end
          rdi_pkg::S_ACK_WORD, rdi_pkg::S_ACK_DATA: begin
            if (scl_fall) begin
              sda_oe_reg <= 1'b0; // RULE8
              bit_cnt_reg <= 3'h0;
              if (state_reg == rdi_pkg::S_ACK_DATA) begin
                ptr_reg <= ptr_inc;
              end
              state_reg <= rdi_pkg::S_WDATA;
            end
          end
          rdi_pkg::S_TX: begin
            if (scl_fall) begin
              if (bit_cnt_reg == 3'(rdi_pkg::BYTE_LAST_BIT)) begin
                sda_oe_reg <= 1'b0; // RULE8
                state_reg <= rdi_pkg::S_MACK;
              end else begin
                shift_reg <= {shift_reg[6:0], 1'b0};
                sda_oe_reg <= ~shift_reg[6]; // RULE2
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
              end
            end
          end
          rdi_pkg::S_MACK: begin
            if (scl_rise) begin
              ack_reg <= ~sda_s; // RULE10
            end else if (scl_fall) begin
              bit_cnt_reg <= 3'h0;
              if (ack_reg) begin
                shift_reg <= rd_byte; // RULE19
                sda_oe_reg <= ~rd_byte[7];
                ptr_reg <= ptr_inc; // RULE20
                state_reg <= rdi_pkg::S_TX;
              end else begin
                state_reg <= rdi_pkg::S_WAIT; // RULE21
              end
            end
          end
          // Standby or ignoring the bus until START or STOP
          rdi_pkg::S_IDLE, rdi_pkg::S_WAIT: begin
            sda_oe_reg <= 1'b0; // RULE21
          end
          default: begin
            state_reg <= rdi_pkg::S_IDLE;
            sda_oe_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////
  // Write notice, one cycle per received data byte, stored or not
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_valid_reg <= 1'b0;
      wr_user_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
    end else if (clk_en) begin
      wr_valid_reg <= mem_we;
      if (mem_we) begin
        wr_user_reg <= user_reg;
        wr_addr_reg <= ptr_reg;
        wr_data_reg <= shift_reg;
      end
    end
  end

  // Status flags; busy lags the state by one cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
      sda_o_reg <= 1'b0;
    end else if (clk_en) begin
      busy_reg <= (state_reg != rdi_pkg::S_IDLE);
      sda_o_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////
  // Outputs
  assign bus.s_sda_oe = sda_oe_reg;
  assign bus.s_sda_o = sda_o_reg;
  assign wr_valid = wr_valid_reg;
  assign wr_user = wr_user_reg;
  assign wr_addr = wr_addr_reg;
  assign wr_data = wr_data_reg;
  assign busy = busy_reg;
  assign ready = ready_reg;

endmodule : rdi_slave

// ==== src/rdi_pkg.sv ====
package rdi_pkg;

  ////////////////////////////////////////
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int PWRUP_NS = 1000;
  // Least time, rounded up to whole cycles
  localparam logic [7:0] PWRUP_CYC = 8'((PWRUP_NS * CLK_MHZ + 999) / 1000);
  // Quarter of the bus clock period the host makes, rounded down
  localparam int SCL_QTR_NS = 625;
  localparam logic [7:0] SCL_QTR_CYC = 8'((SCL_QTR_NS * CLK_MHZ) / 1000);

  ////////////////////////////////////////
  // Addressing
  localparam logic [6:0] ID_REGS = 7'h6f;
  localparam logic [6:0] ID_USER = 7'h57;
  localparam logic [7:0] REG_LAST = 8'h2f;
  localparam logic [7:0] USER_LAST = 8'h7f;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam int REG_DEPTH = 48;
  localparam int USER_DEPTH = 128;
  localparam int BYTE_LAST_BIT = 7;
  localparam int ACK_BIT = 8;

  ////////////////////////////////////////
  // Read buffer
  localparam int FIFO_W = 8;
  localparam int FIFO_DEPTH = 32;

  ////////////////////////////////////////
  // States
  typedef enum logic [3:0] {
    S_IDLE, S_ID, S_ACK_ID, S_WORD, S_ACK_WORD, S_WDATA, S_ACK_DATA,
    S_TX, S_MACK, S_WAIT
  } rdi_slv_state_type;

  typedef enum logic [2:0] {
    M_IDLE, M_START, M_TX, M_RX, M_STOP
  } rdi_mst_state_type;

endpackage : rdi_pkg

// ==== src/rdi_if.sv ====
// Open-drain two-wire bus; an enable pulls its line low
interface rdi_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // Wired-and with pull-ups
  assign scl = ~(m_scl_oe & ~m_scl_o);
  assign sda = ~(m_sda_oe & ~m_sda_o) & ~(s_sda_oe & ~s_sda_o);

  modport dev (input scl, input sda, output s_sda_o, output s_sda_oe);
  modport host (input scl, input sda, output m_scl_o, output m_scl_oe,
                output m_sda_o, output m_sda_oe);
endinterface : rdi_if

// ==== src/rdi_master.sv ====
// Read buffer with a registered output stage
module rdi_fifo #(
  parameter int W = rdi_pkg::FIFO_W,
  parameter int DEPTH = rdi_pkg::FIFO_DEPTH
) (
  // Clock, reset, freeze
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign push = in_valid & in_ready;
  assign pop = (cnt_reg != '0) & (out_ready | ~out_valid);

  // Storage array
  always_ff @(posedge ref_clk) begin
    if (clk_en && push) begin
      mem[wp_reg] <= in_data;
    end
  end

  // Pointers, count and output stage
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (clk_en) begin
      if (push) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= rp_reg + 1'b1;
        out_data <= mem[rp_reg];
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : rdi_fifo

////////////////////////////////////////
// Bus master: makes the clock by division, runs write and random read
module rdi_master (
  // Clock, reset, freeze
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Two-wire bus
  rdi_if.host bus,
  // Command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic cmd_user,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic [5:0] cmd_len,
  // Result
  output logic done,
  output logic nack,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data
);
  rdi_pkg::rdi_mst_state_type state_reg;
  logic [1:0] sda_sync_reg;
  logic [7:0] tcnt_reg;
  logic [1:0] q_reg;
  logic [3:0] bit_reg;
  logic [1:0] stage_reg;
  logic [7:0] sh_reg;
  logic [5:0] left_reg;
  logic rd_cmd_reg;
  logic [6:0] id_reg;
  logic [7:0] addr_reg;
  logic [7:0] wdata_reg;
  logic scl_oe_reg;
  logic sda_oe_reg;
  logic cmd_ready_reg;
  logic done_reg;
  logic nack_reg;
  logic push;
  logic fifo_ready;
  logic tick;
  logic stall;
  logic last_bit;
  logic ack_slot;

  // Read data passes the buffer; a full buffer holds the clock low
  rdi_fifo #(.W(rdi_pkg::FIFO_W), .DEPTH(rdi_pkg::FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .in_valid(push), .in_ready(fifo_ready), .in_data(sh_reg),
    .out_valid(rd_valid), .out_ready(rd_ready), .out_data(rd_data)
  );

  // Data line synchroniser
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_sync_reg <= 2'h3;
    end else if (clk_en) begin
      sda_sync_reg <= {sda_sync_reg[0], bus.sda};
    end
  end

  assign ack_slot = (bit_reg == 4'(rdi_pkg::ACK_BIT));
  assign last_bit = (bit_reg == 4'(rdi_pkg::BYTE_LAST_BIT));
  assign tick = (tcnt_reg == rdi_pkg::SCL_QTR_CYC - 8'h01);
  assign stall = (state_reg == rdi_pkg::M_RX) & (q_reg == 2'h0) & ack_slot & ~fifo_ready;
  assign push = tick & (state_reg == rdi_pkg::M_RX) & (q_reg == 2'h0) & ack_slot & fifo_ready;

  // Quarter-period divider
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tcnt_reg <= 8'h00;
    end else if (clk_en) begin
      tcnt_reg <= (tick || state_reg == rdi_pkg::M_IDLE) ? 8'h00 : tcnt_reg + 8'h01;
    end
  end

  // Sequencer: quarter 0 sets data, 1 raises clock, 2 samples, 3 lowers clock
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= rdi_pkg::M_IDLE;
      q_reg <= 2'h0;
      bit_reg <= 4'h0;
      stage_reg <= 2'h0;
      sh_reg <= 8'h00;
      left_reg <= 6'h00;
      rd_cmd_reg <= 1'b0;
      id_reg <= 7'h00;
      addr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      cmd_ready_reg <= 1'b1;
      done_reg <= 1'b0;
      nack_reg <= 1'b0;
    end else if (clk_en) begin
      done_reg <= 1'b0;
      if (state_reg == rdi_pkg::M_IDLE) begin
        if (cmd_valid && cmd_ready_reg) begin
          rd_cmd_reg <= cmd_read;
          id_reg <= cmd_user ? rdi_pkg::ID_USER : rdi_pkg::ID_REGS;
          addr_reg <= cmd_addr;
          wdata_reg <= cmd_wdata;
          left_reg <= (cmd_len == 6'h00) ? 6'h01 : cmd_len;
          cmd_ready_reg <= 1'b0;
          nack_reg <= 1'b0;
          stage_reg <= 2'h0;
          q_reg <= 2'h0;
          state_reg <= rdi_pkg::M_START;
        end
      end else if (tick && !stall) begin
        q_reg <= q_reg + 2'h1;
        case (q_reg)
          2'h0: begin
            if (state_reg == rdi_pkg::M_START) begin
              sda_oe_reg <= 1'b0;
            end else if (state_reg == rdi_pkg::M_STOP) begin
              sda_oe_reg <= 1'b1;
            end else if (state_reg == rdi_pkg::M_TX) begin
              sda_oe_reg <= ~ack_slot & ~sh_reg[7];
            end else begin
              sda_oe_reg <= ack_slot & (left_reg != 6'h01);
            end
          end
          2'h1: begin
            scl_oe_reg <= 1'b0;
          end
          2'h2: begin
            if (state_reg == rdi_pkg::M_START) begin
              sda_oe_reg <= 1'b1;
            end else if (state_reg == rdi_pkg::M_STOP) begin
              sda_oe_reg <= 1'b0;
            end else if (state_reg == rdi_pkg::M_RX && !ack_slot) begin
              sh_reg <= {sh_reg[6:0], sda_sync_reg[1]};
            end
          end
          default: begin
            if (state_reg == rdi_pkg::M_STOP) begin
              state_reg <= rdi_pkg::M_IDLE;
              done_reg <= 1'b1;
              cmd_ready_reg <= 1'b1;
            end else begin
              scl_oe_reg <= 1'b1;
              bit_reg <= ack_slot ? 4'h0 : bit_reg + 4'h1;
              if (state_reg == rdi_pkg::M_START) begin
                sh_reg <= {id_reg, stage_reg == 2'h3};
                state_reg <= rdi_pkg::M_TX;
                bit_reg <= 4'h0;
              end else if (state_reg == rdi_pkg::M_TX && !ack_slot) begin
                sh_reg <= {sh_reg[6:0], 1'b0};
              end else if (state_reg == rdi_pkg::M_TX && sda_sync_reg[1]) begin
                nack_reg <= 1'b1;
                state_reg <= rdi_pkg::M_STOP;
              end else if (state_reg == rdi_pkg::M_TX) begin
                stage_reg <= stage_reg + 2'h1;
                if (stage_reg == 2'h0) begin
                  sh_reg <= addr_reg;
                end else if (stage_reg == 2'h1 && rd_cmd_reg) begin
                  stage_reg <= 2'h3;
                  state_reg <= rdi_pkg::M_START;
                end else if (stage_reg == 2'h1) begin
                  sh_reg <= wdata_reg;
                end else if (stage_reg == 2'h2) begin
                  state_reg <= rdi_pkg::M_STOP;
                end else begin
                  state_reg <= rdi_pkg::M_RX;
                end
              end else if (ack_slot) begin
                left_reg <= left_reg - 6'h01;
                if (left_reg == 6'h01) begin
                  state_reg <= rdi_pkg::M_STOP;
                end
              end
            end
          end
        endcase
      end
    end
  end

  assign bus.m_scl_oe = scl_oe_reg;
  assign bus.m_scl_o = 1'b0;
  assign bus.m_sda_oe = sda_oe_reg;
  assign bus.m_sda_o = 1'b0;
  assign cmd_ready = cmd_ready_reg;
  assign done = done_reg;
  assign nack = nack_reg;

endmodule : rdi_master

// ==== dv/rdi_checker.sv ====
module rdi_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Resolved lines and data drives
  input wire logic scl,
  input wire logic sda,
  input wire logic s_sda_oe,
  input wire logic m_sda_oe
);
  logic p_scl, p_sda, rise, start, stop, first, rd_dir, nacked, ack9;
  logic [3:0] bcnt;
  logic [7:0] sh, lo_cnt, pw_cnt;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // Line events from one cycle of history
  assign rise = scl & ~p_scl;
  assign start = scl & p_scl & p_sda & ~sda;
  assign stop = scl & p_scl & ~p_sda & sda;
  assign ack9 = rise & (bcnt == 4'h8);

  ////////////////////////////////////////
  // History resets high so a reset never fakes a clock rise or a STOP
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      p_scl <= 1'b1;
      p_sda <= 1'b1;
    end else begin
      p_scl <= scl;
      p_sda <= sda;
    end
  end

  // Bit position; first marks the byte right after a START
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bcnt <= 4'h0;
      first <= 1'b0;
    end else if (start) begin
      bcnt <= 4'h0;
      first <= 1'b1;
    end else if (rise && bcnt == 4'h8) begin
      bcnt <= 4'h0;
      first <= 1'b0;
    end else if (rise) begin
      bcnt <= bcnt + 4'h1;
    end
  end

  // Shifted byte, direction and a refused read byte
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sh <= 8'h00;
      rd_dir <= 1'b0;
      nacked <= 1'b0;
    end else begin
      if (rise) sh <= {sh[6:0], sda};
      if (rise && bcnt == 4'h8 && first) rd_dir <= sh[0];
      if (start || stop) nacked <= 1'b0;
      else if (rise && bcnt == 4'h8 && !first && rd_dir && sda) nacked <= 1'b1;
    end
  end

  // Time since scl fell and since reset, both saturating
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_cnt <= 8'h00;
      pw_cnt <= 8'h00;
    end else begin
      lo_cnt <= scl ? 8'h00 : (lo_cnt == 8'hff ? lo_cnt : lo_cnt + 8'h01);
      pw_cnt <= (pw_cnt == 8'hff) ? pw_cnt : pw_cnt + 8'h01;
    end
  end

  ////////////////////////////////////////
  chk_pwrup_quiet: assert property ((pw_cnt < rdi_pkg::PWRUP_CYC) |-> !s_sda_oe)
    else $error("slave drove during power-up");
  chk_drive_scl_low: assert property ($changed(s_sda_oe) |-> !scl)
    else $error("slave data changed with clock high");
  chk_scl_high_min: assert property ($rose(scl) |=> scl [*8])
    else $error("clock high phase too short");
  chk_drive_delay: assert property ($rose(s_sda_oe) |->
    (lo_cnt >= 8'h02 && lo_cnt <= 8'h06)) else $error("drive late");
  chk_id_ack: assert property ((ack9 && first) |->
    (!sda == (sh[7:1] == rdi_pkg::ID_REGS || sh[7:1] == rdi_pkg::ID_USER)))
    else $error("identifier ack wrong");
  chk_write_ack: assert property ((ack9 && !first && !rd_dir) |-> !sda)
    else $error("write byte not acked");
  chk_slave_release: assert property ((ack9 && !first && rd_dir) |-> !s_sda_oe)
    else $error("slave held ack bit");
  chk_host_release: assert property ((ack9 && (first || !rd_dir)) |-> !m_sda_oe)
    else $error("host held ack");
  chk_nack_quiet: assert property (nacked |-> !s_sda_oe)
    else $error("slave drove after refused byte");
  chk_stop_idle: assert property (stop |=> !s_sda_oe [*8])
    else $error("slave drove after stop");
endmodule : rdi_checker

// ==== dv/tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic cmd_user = 1'b0;
  logic [7:0] cmd_addr = 8'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic [5:0] cmd_len = 6'h01;
  logic rd_ready = 1'b1;
  logic cmd_ready, done, nack, rd_valid, wr_valid, wr_user, busy, ready;
  logic [7:0] rd_data, wr_addr, wr_data, sh;
  logic [16:0] wr_seen;
  logic [7:0] rd_q[$];
  logic [7:0] id_q[$];
  int mismatches = 0;
  int n_checks = 0;
  int wr_cnt = 0;
  int nb = 100;

  rdi_if bus();
  rdi_slave rdi_slave_i (.ref_clk, .rst_n, .clk_en, .bus(bus), .wr_valid, .wr_user, .wr_addr,
    .wr_data, .busy, .ready);
  rdi_master rdi_master_i (.ref_clk, .rst_n, .clk_en, .bus(bus), .cmd_valid, .cmd_ready,
    .cmd_read, .cmd_user, .cmd_addr, .cmd_wdata, .cmd_len, .done, .nack, .rd_valid,
    .rd_ready, .rd_data);
  rdi_checker rdi_checker_i (.ref_clk, .rst_n, .scl(bus.scl), .sda(bus.sda),
    .s_sda_oe(bus.s_sda_oe), .m_sda_oe(bus.m_sda_oe));

  // 200 MHz clock
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Collect write notices, stored or not, and the read stream
  always @(posedge ref_clk) begin
    if (wr_valid === 1'b1) begin
      wr_seen <= {wr_user, wr_addr, wr_data};
      wr_cnt++;
    end
    if (rd_valid === 1'b1 && rd_ready === 1'b1) rd_q.push_back(rd_data);
  end

  // Wire monitor: the first byte after each START, shifted in as sent
  always @(negedge bus.sda) if (bus.scl === 1'b1) nb = 0;
  always @(posedge bus.scl) begin
    sh = {sh[6:0], bus.sda};
    nb++;
    if (nb == 8) id_q.push_back(sh);
  end

  ////////////////////////////////////////
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [16:0] idb(input logic u, input logic r);
    return {9'h000, (u ? rdi_pkg::ID_USER : rdi_pkg::ID_REGS), r};
  endfunction : idb

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  // One command, held until taken; the wait for done is bounded
  task automatic run_cmd(input logic r, input logic u, input logic [7:0] a,
      input logic [7:0] d, input logic [5:0] n);
    int i;
    @(negedge ref_clk);
    cmd_read = r;
    cmd_user = u;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_len = n;
    cmd_valid = 1'b1;
    for (i = 0; i < 100 && cmd_ready !== 1'b1; i++) @(negedge ref_clk);
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    for (i = 0; i < 40000 && done !== 1'b1; i++) @(negedge ref_clk);
    if (i == 40000) begin
      mismatches++;
      $display("BAD %0t no done", $time);
      close_out();
    end
    repeat (10) @(negedge ref_clk);
  endtask : run_cmd

  ////////////////////////////////////////
  task automatic t_powerup();
    int i;
    repeat (150) @(negedge ref_clk);
    check(17'(ready), 17'h0);
    check(17'(bus.s_sda_oe), 17'h0);
    check(17'(busy), 17'h0);
    for (i = 150; i < 400 && ready !== 1'b1; i++) @(negedge ref_clk);
    check(17'(i > 195 && i < 210), 17'h1);
    $display("test powerup done");
  endtask : t_powerup

  task automatic t_write(input logic u, input logic [7:0] a, input logic [7:0] d);
    int n0;
    n0 = wr_cnt;
    run_cmd(1'b0, u, a, d, 6'h01);
    check(17'(nack), 17'h0);
    check(wr_seen, {u, a, d});
    check(17'(wr_cnt - n0), 17'h1);
    check(17'(busy), 17'h0);
    check(17'(cmd_ready), 17'h1);
    check(17'(id_q.size()), 17'h1);
    check(17'(id_q[0]), idb(u, 1'b0));
    id_q.delete();
    $display("test write done");
  endtask : t_write

  // Host stalls the read stream so bytes wait in its buffer
  task automatic t_read(input logic u, input logic [7:0] a, input logic [5:0] n,
      input logic [7:0] e0, input logic [7:0] e1);
    int i;
    rd_q.delete();
    rd_ready = 1'b0;
    run_cmd(1'b1, u, a, 8'h00, n);
    check(17'(rd_valid), 17'h1);
    rd_ready = 1'b1;
    for (i = 0; i < 50 && rd_q.size() < n; i++) @(negedge ref_clk);
    check(17'(rd_q.size()), 17'(n));
    check(17'(rd_valid), 17'h0);
    check(17'(busy), 17'h0);
    check(17'(rd_q[0]), 17'(e0));
    if (n > 6'h01) check(17'(rd_q[1]), 17'(e1));
    check(17'(nack), 17'h0);
    check(17'(id_q.size()), 17'h2);
    check(17'(id_q[0]), idb(u, 1'b0));
    check(17'(id_q[1]), idb(u, 1'b1));
    id_q.delete();
    $display("test read done");
  endtask : t_read

  ////////////////////////////////////////
  initial begin
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    t_powerup();
    t_write(1'b0, 8'h2f, 8'ha5);
    t_write(1'b0, 8'h00, 8'h5a);
    t_write(1'b1, 8'h7f, 8'h3c);
    t_read(1'b0, 8'h2f, 6'h02, 8'ha5, 8'h5a);
    t_read(1'b1, 8'h7f, 6'h01, 8'h3c, 8'h00);
    close_out();
  end
endmodule : tb_top
